// ---- clkgen_ctrl.sv ----
// clock generator mode control: mode sequencing, lock tracking, loss handling, bus divider
// assumes apb master on CLK; ref/dco/ext activity given as one-cycle tick inputs on CLK
//
// Our own choices: the APB slave port and the register addresses.
`include "clkgen_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module clkgen_ctrl (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic STOP_REQ,
	input wire logic INT_REF_TICK,
	input wire logic EXT_REF_TICK,
	input wire logic DCO_TICK,
	output logic [1:0] CLK_SRC_SEL,
	output logic [2:0] BUS_DIV_SEL,
	output logic GEN_OUT_STATIC,
	output logic [11:0] DCO_FILTER,
	output logic DCO_CLOSED_LOOP,
	output logic HIGH_GAIN_SELECT,
	output logic RANGE_HIGH,
	output logic [7:0] INTERNAL_REF_TRIM,
	output logic FIXED_FREQ_ENABLE,
	output logic DEBUG_LOCAL_CLOCK_SEL,
	output logic RTI_SELF_CLOCKED,
	output logic LOSS_RESET_REQ,
	output logic LOSS_IRQ_REQ
);
	typedef struct packed {
		clkgen_pkg::gen_state_t st;
		logic [7:0] c1;
		logic [7:0] c2;
		logic first_done;
		logic ext_reserved;
		logic [11:0] filt;
		logic [7:0] trim;
		logic refst;
		logic lols;
		logic locs;
		logic lock_q;
		logic [15:0] ref_idle;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic rst_req;
		logic irq_req;
		logic [1:0] src;
	} ctrl_state_t;

	ctrl_state_t s_q, s_d;
	logic locked, window_done, engaged, ref_tick, wr, rd;
	logic [1:0] req_mode;
	logic [15:0] prescale, target;

	assign req_mode = s_q.c1[`C1_CLOCK_MODE_SELECT_LO +: 2];
	assign prescale = s_q.c1[`C1_RANGE_BIT] ? `PRESCALE_HIGH : `PRESCALE_LOW;
	assign engaged = (s_q.st == clkgen_pkg::ST_FLL_UNLOCKED) || (s_q.st == clkgen_pkg::ST_FLL_LOCKED);
	assign ref_tick = req_mode[1] ? EXT_REF_TICK : INT_REF_TICK;
	// target: twice the multiplier field plus four, times prescale, in oscillator ticks per window
	assign target = (16'({s_q.c2[`C2_MFD_LO +: 3], 1'b0}) + 16'h0004) * prescale;
	assign wr = PSEL && PENABLE && PWRITE && !s_q.pready;
	assign rd = PSEL && PENABLE && !PWRITE && !s_q.pready;

	clkgen_lock_detect u_lock (
		.clk(CLK),
		.rst_n(RST_N),
		.enable(engaged),
		.ref_tick(ref_tick),
		.dco_tick(DCO_TICK),
		.window_len(prescale),
		.target(target),
		.locked(locked),
		.window_done(window_done)
	);

	always_comb begin
		s_d = s_q;
		s_d.pready = 1'b0;
		s_d.pslverr = 1'b0;
		// reference activity watchdog, external reference valid flag
		if (EXT_REF_TICK) begin
			s_d.ref_idle = 16'h0000;
			s_d.refst = 1'b1;
		end else if (s_q.ref_idle >= `REF_TIMEOUT) begin
			s_d.refst = 1'b0;
		end else begin
			s_d.ref_idle = s_q.ref_idle + 16'h0001;
		end

		// apb slave, answers one cycle after the access phase starts
		if (wr || rd) begin
			s_d.pready = 1'b1;
			s_d.prdata = 32'h0000_0000;
			if (PADDR == `CTRL1_ADDR) begin
				if (wr) begin
					// write-once bits held after first write
					if (!s_q.first_done) begin
						s_d.c1[7:5] = PWDATA[7:5];
						s_d.ext_reserved = PWDATA[`C1_CLOCK_MODE_SELECT_LO + 1];
					end
					s_d.first_done = 1'b1;
					s_d.c1[2:1] = PWDATA[2:1];
					// external modes locked out if pin not reserved
					if (!PWDATA[`C1_CLOCK_MODE_SELECT_LO + 1] || !s_q.first_done || s_q.ext_reserved)
						s_d.c1[`C1_CLOCK_MODE_SELECT_LO +: 2] = PWDATA[`C1_CLOCK_MODE_SELECT_LO +: 2];
				end else
					s_d.prdata = {24'h000000, s_q.c1};
			end else if (PADDR == `CTRL2_ADDR) begin
				if (wr)
					s_d.c2 = PWDATA[7:0];
				else
					s_d.prdata = {24'h000000, s_q.c2};
			end else if (PADDR == `STAT_ADDR) begin
				// status readback, loss flags cleared by read
				if (rd) begin
					s_d.prdata = {28'h0000000, s_q.refst, s_q.lock_q, s_q.lols, s_q.locs};
					s_d.lols = 1'b0;
					s_d.locs = 1'b0;
				end
			end else if (PADDR == `FILT_ADDR) begin
				if (wr)
					s_d.filt = PWDATA[11:0];
				else
					s_d.prdata = {20'h00000, s_q.filt};
			end else if (PADDR == `TRIM_ADDR) begin
				if (wr)
					s_d.trim = PWDATA[7:0];
				else
					s_d.prdata = {24'h000000, s_q.trim};
			end else begin
				s_d.pslverr = 1'b1;
			end
		end

		// mode sequencer
		case (s_q.st)
			clkgen_pkg::ST_OFF: begin
				// filter held, so relock is quick
				if (!STOP_REQ)
					s_d.st = clkgen_pkg::ST_SCM;
			end
			clkgen_pkg::ST_SCM: begin
				if (STOP_REQ)
					s_d.st = clkgen_pkg::ST_OFF;
				else if (req_mode == clkgen_pkg::MODE_FEI)
					s_d.st = clkgen_pkg::ST_FLL_UNLOCKED;
				else if (req_mode == clkgen_pkg::MODE_FBE && s_q.refst)
					s_d.st = clkgen_pkg::ST_BYPASS;
				// engage external loop when reference runs
				else if (req_mode == clkgen_pkg::MODE_FEE && s_q.refst)
					s_d.st = clkgen_pkg::ST_FLL_UNLOCKED;
			end
			clkgen_pkg::ST_FLL_UNLOCKED, clkgen_pkg::ST_FLL_LOCKED: begin
				if (STOP_REQ)
					s_d.st = clkgen_pkg::ST_OFF;
				else if (req_mode == clkgen_pkg::MODE_SCM || req_mode == clkgen_pkg::MODE_FBE)
					s_d.st = clkgen_pkg::ST_SCM;
				else if (window_done)
					s_d.st = locked ? clkgen_pkg::ST_FLL_LOCKED : clkgen_pkg::ST_FLL_UNLOCKED;
				if (window_done && !locked && !(req_mode[1] && !s_q.refst))
					s_d.filt = s_q.filt + 12'h001;
			end
			clkgen_pkg::ST_BYPASS: begin
				// drop back to self clock if reference dies
				if (STOP_REQ)
					s_d.st = clkgen_pkg::ST_OFF;
				else if (req_mode != clkgen_pkg::MODE_FBE || !s_q.refst)
					s_d.st = clkgen_pkg::ST_SCM;
			end
			default: s_d.st = clkgen_pkg::ST_SCM;
		endcase

		// loop output used only once locked
		// bypass routes external reference
		// source follows the next state so it never lags a mode change by a cycle
		case (s_d.st)
			clkgen_pkg::ST_FLL_LOCKED: s_d.src = 2'h1;
			clkgen_pkg::ST_BYPASS: s_d.src = 2'h2;
			default: s_d.src = 2'h0;
		endcase

		// lock and loss-of-lock flags; set wins over read clear
		s_d.lock_q = (s_q.st == clkgen_pkg::ST_FLL_LOCKED);
		if (s_q.lock_q && window_done && !locked && engaged)
			s_d.lols = 1'b1;
		// loss of reference leaves filter untouched
		if (!s_q.c1[`C1_LOCD_BIT] && req_mode[1] && s_q.refst && s_q.ref_idle >= `REF_TIMEOUT
			&& s_q.st != clkgen_pkg::ST_SCM)
			s_d.locs = 1'b1;

		// loss routed to reset or interrupt
		s_d.rst_req = (s_q.lols && s_q.c2[`C2_LOLRE_BIT]) || (s_q.locs && s_q.c2[`C2_LOCRE_BIT]);
		s_d.irq_req = (s_q.lols && !s_q.c2[`C2_LOLRE_BIT]) || (s_q.locs && !s_q.c2[`C2_LOCRE_BIT]);
	end

	// reset into self-clocked with default filter
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			s_q <= '0;
			s_q.st <= clkgen_pkg::ST_SCM;
			s_q.c1 <= `C1_RESET;
			s_q.c2 <= `C2_RESET;
			s_q.filt <= `FILT_RESET;
			s_q.trim <= `TRIM_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// all outputs except RTI_SELF_CLOCKED, which is tied high, come from state flops
	assign PRDATA = s_q.prdata;
	assign PREADY = s_q.pready;
	assign PSLVERR = s_q.pslverr;
	assign CLK_SRC_SEL = s_q.src;
	assign BUS_DIV_SEL = s_q.c2[`C2_RFD_LO +: 3];
	assign GEN_OUT_STATIC = s_q.st[2];
	assign DCO_FILTER = s_q.filt;
	assign DCO_CLOSED_LOOP = s_q.st[0];
	assign HIGH_GAIN_SELECT = s_q.c1[`C1_HGO_BIT];
	assign RANGE_HIGH = s_q.c1[`C1_RANGE_BIT];
	assign INTERNAL_REF_TRIM = s_q.trim;
	// fixed-frequency enable while loop output or bypass is in use
	assign FIXED_FREQ_ENABLE = s_q.src[0] | s_q.src[1];
	assign DEBUG_LOCAL_CLOCK_SEL = s_q.ext_reserved;
	// real-time interrupt clock self-clocked in every mode, off included
	assign RTI_SELF_CLOCKED = 1'b1;
	assign LOSS_RESET_REQ = s_q.rst_req;
	assign LOSS_IRQ_REQ = s_q.irq_req;
endmodule : clkgen_ctrl
`default_nettype wire

// ---- clkgen_ctrl_asserts.sv ----
// port checker for the clock generator control block
// assumes one clock domain, bound onto clkgen_ctrl
`timescale 1ns/1ps
`default_nettype none
module clkgen_ctrl_asserts (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic STOP_REQ,
	input wire logic [1:0] CLK_SRC_SEL,
	input wire logic [11:0] DCO_FILTER,
	input wire logic DCO_CLOSED_LOOP,
	input wire logic GEN_OUT_STATIC,
	input wire logic RTI_SELF_CLOCKED
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	// bus answer timing
	ans_delay_a: assert property (PSEL && $rose(PENABLE) |=> PREADY) else $error("late answer");
	ready_pulse_a: assert property (PREADY |=> !PREADY) else $error("ready held");
	err_ready_a: assert property (PSLVERR |-> PREADY) else $error("lone error");
	// mode and source relations
	stop_static_a: assert property ($rose(STOP_REQ) |-> ##[1:4] GEN_OUT_STATIC) else $error("clock runs");
	rti_self_a: assert property (RTI_SELF_CLOCKED) else $error("rti source");
	lock_loop_a: assert property (CLK_SRC_SEL == 2'h1 |-> DCO_CLOSED_LOOP) else $error("open loop");
	bypass_open_a: assert property (CLK_SRC_SEL == 2'h2 |-> !DCO_CLOSED_LOOP) else $error("loop used");
	// filter may only move by a bus write while the loop is open
	hold_freq_a: assert property (!DCO_CLOSED_LOOP && !PSEL |=> $stable(DCO_FILTER)) else $error("drift");
	cover property (CLK_SRC_SEL == 2'h1);
	cover property (CLK_SRC_SEL == 2'h2);
	cover property (PSLVERR);
	cover property (GEN_OUT_STATIC);
endmodule : clkgen_ctrl_asserts
bind clkgen_ctrl clkgen_ctrl_asserts chk (.CLK, .RST_N, .PSEL, .PENABLE, .PREADY, .PSLVERR, .STOP_REQ,
	.CLK_SRC_SEL, .DCO_FILTER, .DCO_CLOSED_LOOP, .GEN_OUT_STATIC, .RTI_SELF_CLOCKED);
`default_nettype wire

// ---- clkgen_lock_detect.sv ----
// lock detector: counts oscillator ticks over a reference window and compares to target
// assumes ref_tick and dco_tick are one-cycle pulses synchronous to clk
`include "clkgen_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module clkgen_lock_detect (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic enable,
	input wire logic ref_tick,
	input wire logic dco_tick,
	input wire logic [15:0] window_len,
	input wire logic [15:0] target,
	output logic locked,
	output logic window_done
);
	clkgen_pkg::lock_state_t s_q, s_d;
	logic [15:0] diff;

	always_comb begin
		s_d = s_q;
		s_d.lock_hit = 1'b0;
		diff = (s_q.dco_cnt > target) ? s_q.dco_cnt - target : target - s_q.dco_cnt;
		if (!enable) begin
			s_d.dco_cnt = 16'h0000;
			s_d.win_cnt = 16'h0000;
			s_d.locked = 1'b0;
		end else begin
			if (dco_tick)
				s_d.dco_cnt = s_q.dco_cnt + 16'h0001;
			if (ref_tick) begin
				if (s_q.win_cnt + 16'h0001 >= window_len) begin
					s_d.locked = (diff <= `LOCK_TOL);
					s_d.lock_hit = 1'b1;
					s_d.win_cnt = 16'h0000;
					s_d.dco_cnt = 16'h0000;
				end else begin
					s_d.win_cnt = s_q.win_cnt + 16'h0001;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign locked = s_q.locked;
	assign window_done = s_q.lock_hit;
endmodule : clkgen_lock_detect
`default_nettype wire

// ---- clkgen_pkg.sv ----
// types shared by the clock generator modules
// assumes clkgen_regs.svh supplies the numeric constants
package clkgen_pkg;
	// gray codes along the path self-clocked, unlocked, locked
	typedef enum logic [2:0] {
		ST_OFF = 3'b100,
		ST_SCM = 3'b000,
		ST_FLL_UNLOCKED = 3'b001,
		ST_FLL_LOCKED = 3'b011,
		ST_BYPASS = 3'b010
	} gen_state_t;

	typedef enum logic [1:0] {
		MODE_SCM = 2'b00,
		MODE_FEI = 2'b01,
		MODE_FBE = 2'b10,
		MODE_FEE = 2'b11
	} clock_mode_t;

	typedef struct packed {
		logic [15:0] dco_cnt;
		logic [15:0] win_cnt;
		logic locked;
		logic lock_hit;
	} lock_state_t;
endpackage : clkgen_pkg

// ---- clkgen_regs.svh ----
// register map, field positions, reset values and timing counts of the clock generator
// assumes inclusion by the design modules and the testbench; definitions only
`ifndef CLKGEN_REGS_SVH
`define CLKGEN_REGS_SVH

// register byte addresses on the apb bus
`define CTRL1_ADDR 12'h000
`define CTRL2_ADDR 12'h004
`define STAT_ADDR 12'h008
`define FILT_ADDR 12'h00C
`define TRIM_ADDR 12'h010

// control 1 fields
`define C1_HGO_BIT 7
`define C1_RANGE_BIT 6
`define C1_REFS_BIT 5
`define C1_CLOCK_MODE_SELECT_LO 3
`define C1_OSCSTEN_BIT 2
`define C1_LOCD_BIT 1
`define C1_RESET 8'h00

// control 2 fields
`define C2_LOLRE_BIT 7
`define C2_MFD_LO 4
`define C2_LOCRE_BIT 3
`define C2_RFD_LO 0
`define C2_RESET 8'h00

// status fields
`define ST_REFST_BIT 3
`define ST_LOCK_BIT 2
`define ST_LOLS_BIT 1
`define ST_LOCS_BIT 0

// reset values
`define FILT_RESET 12'h200
`define TRIM_RESET 8'h80

// timing counts
`define PRESCALE_LOW 16'h0040
`define PRESCALE_HIGH 16'h0001
`define LOCK_TOL 16'h0004
`define REF_TIMEOUT 16'h0100

`endif

// ---- testbench.sv ----
// self-checking bench for the clock generator control block
// assumes the block alone on a 250 MHz clock, bench is the apb master
`include "clkgen_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic CLK, RST_N, PSEL, PENABLE, PWRITE, STOP_REQ, PREADY, PSLVERR;
	logic [11:0] PADDR, DCO_FILTER, filt;
	logic [31:0] PWDATA, PRDATA;
	logic INT_REF_TICK = 1'b0, EXT_REF_TICK = 1'b0, DCO_TICK = 1'b0, int_en = 1'b0, ext_en = 1'b0;
	logic [1:0] CLK_SRC_SEL;
	logic [2:0] BUS_DIV_SEL;
	logic [7:0] INTERNAL_REF_TRIM, trim;
	logic GEN_OUT_STATIC, DCO_CLOSED_LOOP, HIGH_GAIN_SELECT, RANGE_HIGH, FIXED_FREQ_ENABLE;
	logic DEBUG_LOCAL_CLOCK_SEL, RTI_SELF_CLOCKED, LOSS_RESET_REQ, LOSS_IRQ_REQ;
	logic [3:0] tc = 4'h0;
	logic [33:0] notes[$];
	int n_mismatch = 0, n_compared = 0, cyc = 0;
	clkgen_ctrl dut (.CLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
		.STOP_REQ, .INT_REF_TICK, .EXT_REF_TICK, .DCO_TICK, .CLK_SRC_SEL, .BUS_DIV_SEL, .GEN_OUT_STATIC,
		.DCO_FILTER, .DCO_CLOSED_LOOP, .HIGH_GAIN_SELECT, .RANGE_HIGH, .INTERNAL_REF_TRIM,
		.FIXED_FREQ_ENABLE, .DEBUG_LOCAL_CLOCK_SEL, .RTI_SELF_CLOCKED, .LOSS_RESET_REQ, .LOSS_IRQ_REQ);
	initial begin
		CLK = 1'b0;
		forever #2 CLK = ~CLK;
	end
	// four oscillator ticks per reference tick, so a window meets its target while the multiplier field is zero
	always @(posedge CLK) begin
		tc <= tc + 4'h1;
		INT_REF_TICK <= int_en && tc == 4'h0;
		EXT_REF_TICK <= ext_en && tc == 4'h0;
		DCO_TICK <= tc[1:0] == 2'h0;
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_mismatch++;
			finish_test();
		end
	end
	// answers are read mid-cycle, where the one-cycle pulse is settled
	always @(negedge CLK) if (PREADY === 1'b1 && notes.size() > 0) begin
		logic [33:0] n;
		n = notes.pop_front();
		n_compared++;
		if (PSLVERR !== n[32] || (n[33] && PRDATA !== n[31:0])) begin
			n_mismatch++;
			$display("BAD %0t answer %h", $time, PRDATA);
		end
	end
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e, c);
		notes.push_back({c, e, d});
		@(posedge CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		// hold the request until pready is sampled high at a rising edge
		do @(posedge CLK); while (PREADY !== 1'b1);
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(negedge CLK);
	endtask : xfer
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, 1'b0, 1'b0);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b0, a, d, 1'b0, 1'b1);
	endtask : rd
	task automatic chk(input logic [31:0] got, exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t port %h not %h", $time, got, exp);
		end
	endtask : chk
	task automatic do_reset();
		@(posedge CLK);
		RST_N <= 1'b0;
		repeat (12) @(posedge CLK);
		RST_N <= 1'b1;
		@(negedge CLK);
		chk({CLK_SRC_SEL, DCO_CLOSED_LOOP, GEN_OUT_STATIC, RTI_SELF_CLOCKED, DCO_FILTER, INTERNAL_REF_TRIM},
			{2'h0, 3'h1, 12'h200, 8'h80});
	endtask : do_reset
	task automatic finish_test();
		if (n_mismatch == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : finish_test
	// main sequence: registers, then every mode in turn
	initial begin
		{RST_N, PSEL, PENABLE, PWRITE, STOP_REQ, PADDR, PWDATA} = '0;
		void'($urandom(65151));
		{filt, trim} = 20'($urandom);
		do_reset();
		rd(`CTRL1_ADDR, 32'h0);
		xfer(1'b0, 12'h014, 32'h0, 1'b1, 1'b0);
		wr(`TRIM_ADDR, {24'h0, trim});
		rd(`TRIM_ADDR, {24'h0, trim});
		wr(`FILT_ADDR, {20'h0, filt});
		chk({INTERNAL_REF_TRIM, DCO_FILTER}, {trim, filt});
		for (int i = 0; i < 8; i++) begin
			wr(`CTRL2_ADDR, 32'(i));
			chk(BUS_DIV_SEL, 32'(i));
		end
		wr(`CTRL1_ADDR, 32'hD0);
		chk({HIGH_GAIN_SELECT, RANGE_HIGH, CLK_SRC_SEL}, 4'hC);
		wr(`CTRL1_ADDR, 32'h10);
		rd(`CTRL1_ADDR, 32'hD0);
		ext_en = 1'b1;
		repeat (2000) if (CLK_SRC_SEL !== 2'h2) @(negedge CLK);
		chk({CLK_SRC_SEL, DCO_CLOSED_LOOP}, 3'h4);
		xfer(1'b0, `STAT_ADDR, 32'h0, 1'b0, 1'b0);
		rd(`STAT_ADDR, 32'h8);
		wr(`CTRL1_ADDR, 32'hD8);
		repeat (2000) if (CLK_SRC_SEL !== 2'h1) @(negedge CLK);
		chk({CLK_SRC_SEL, DCO_CLOSED_LOOP}, 3'h3);
		chk({FIXED_FREQ_ENABLE, DEBUG_LOCAL_CLOCK_SEL}, 2'h3);
		rd(`STAT_ADDR, 32'hC);
		// a lost reference raises the interrupt, or the reset once configured so
		for (int i = 0; i < 2; i++) begin
			wr(`CTRL2_ADDR, i ? 32'h8 : 32'h0);
			ext_en = 1'b0;
			repeat (800) if ({LOSS_RESET_REQ, LOSS_IRQ_REQ} === 2'h0) @(negedge CLK);
			chk({LOSS_RESET_REQ, LOSS_IRQ_REQ}, i ? 2'h2 : 2'h1);
			ext_en = 1'b1;
			repeat (300) @(negedge CLK);
			xfer(1'b0, `STAT_ADDR, 32'h0, 1'b0, 1'b0);
		end
		filt = DCO_FILTER;
		@(posedge CLK);
		STOP_REQ <= 1'b1;
		repeat (8) @(negedge CLK);
		chk(GEN_OUT_STATIC, 1'b1);
		@(posedge CLK);
		STOP_REQ <= 1'b0;
		repeat (4) @(negedge CLK);
		chk(DCO_FILTER, filt);
		ext_en = 1'b0;
		do_reset();
		int_en = 1'b1;
		wr(`CTRL1_ADDR, 32'h08);
		repeat (6000) if (CLK_SRC_SEL !== 2'h1) @(negedge CLK);
		chk(DCO_CLOSED_LOOP, 1'b1);
		wr(`CTRL1_ADDR, 32'h10);
		rd(`CTRL1_ADDR, 32'h08);
		chk(CLK_SRC_SEL, 2'h1);
		finish_test();
	end
endmodule : testbench
`default_nettype wire
